//--- hw/flic_pkg.sv
// Functional notes
// [RQ1] Level per source from high bit and low bit; 00 lowest, 11 highest.
// [RQ2] Preempt only by strictly higher level; level 3 never preempted.
// [RQ3] Ties at one level go to smallest natural rank, 1 to 11.
// [RQ4] Vectors 0003H..0053H step eight; shared sources OR their flags.
// [RQ5] Only external, wake timer and brown-out requests wake from power-down.
// [RQ6] Edge external flags clear on vectoring; level flags follow inverted pin.
// [RQ7] Timer zero/one flags clear on vectoring; third timer flag does not.
// [RQ8] Flags sampled each machine cycle; polled and resolved same cycle.
// [RQ9] Call only if not blocked, last cycle, no enable/priority write or RETI.
// [RQ10] Denied requests are not remembered; each poll is fresh.
// [RQ11] Grant pushes program counter without status word, then loads vector.
// [RQ12] RETI pops and ends service level; plain RET leaves service set.
// [RQ13] External zero and one latched one cycle, polled the next.
// [RQ14] Call takes two machine cycles; at least three from flag to routine.
// [RQ15] Single-routine response never exceeds nine machine cycles.
// [RQ16] Global enable gates all; each source needs its own enable.
// [RQ17] Software-set flags interrupt exactly like hardware-set ones.
// [RQ18] One in-service bit per level; set on call, highest cleared on RETI.
package flic_pkg;
    localparam int NSRC = 11;
    localparam int NLVL = 4;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    localparam logic [3:0] CALL_CYCLES = 4'h2;
    localparam logic [3:0] MAX_RESPONSE = 4'h9;
    // Source indices in natural order (rank = index + 1)
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMRA = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMRB = 3;
    localparam int SRC_UART = 4;
    localparam int SRC_TMRC = 5;
    localparam int SRC_EXT2 = 6;
    localparam int SRC_EXT3 = 7;
    localparam int SRC_SPI = 8;
    localparam int SRC_WAKE = 9;
    localparam int SRC_BOD = 10;
    localparam logic [NSRC-1:0] WAKE_MASK = 11'h6C5;
    localparam logic [3:0] EXT_RESET = 4'h0;
    localparam logic [NLVL-1:0] INSVC_RESET = 4'h0;

    typedef struct packed {
        logic lastCycle;
        logic writesCfg;
        logic isReti;
    } flic_core_t;

    typedef struct packed {
        logic valid;
        logic [3:0] src;
        logic [1:0] level;
        logic [15:0] vector;
    } flic_grant_t;
endpackage

//--- hw/flic_edge_latch.sv
`timescale 1ns/1ps
// External pin request flags with edge/level behaviour
module flic_edge_latch
    import flic_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Pins and control
    input wire logic [3:0] extPinN,
    input wire logic [3:0] extTriggerType,
    input wire logic [3:0] swSet,
    input wire logic [3:0] swClr,
    input wire logic [3:0] vecClr,
    // Flags
    output logic [3:0] extFlag
);
    logic [3:0] pinPrev_ff;
    logic [3:0] flag_ff;
    wire [3:0] fallEdge = pinPrev_ff & ~extPinN;
    // [RQ6] edge clears on vector
    wire [3:0] edgeNext = fallEdge | swSet | (flag_ff & ~swClr & ~vecClr);
    wire [3:0] nxt_flag = (extTriggerType & edgeNext) | (~extTriggerType & ~extPinN);

    // [RQ13] latch pin each cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pinPrev_ff <= 4'hF;
            flag_ff <= EXT_RESET;
        end else begin
            pinPrev_ff <= extPinN;
            flag_ff <= nxt_flag;
        end
    end
    assign extFlag = flag_ff;
endmodule

//--- hw/flic_ctrl.sv
`timescale 1ns/1ps
// Four-level interrupt controller, one clock edge per machine cycle
module flic_ctrl
    import flic_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // External pins and trigger types (1 = falling edge)
    input wire logic [3:0] extPinN,
    input wire logic [3:0] extTriggerType,
    input wire logic [3:0] extSwSet,
    input wire logic [3:0] extSwClr,
    // Other source flags, kept by their peripherals
    input wire logic timerAOverflowFlag,
    input wire logic timerBOverflowFlag,
    input wire logic timerCOverflowFlag,
    input wire logic timerCExternalFlag,
    input wire logic serialReceiveFlag,
    input wire logic serialTransmitFlag,
    input wire logic spiDoneFlag,
    input wire logic spiFaultFlag,
    input wire logic spiOverrunFlag,
    input wire logic wakeTimerFlag,
    input wire logic brownoutFlag,
    // Enables and priority bits, bit index = source index
    input wire logic globalIrqEnable,
    input wire logic [NSRC-1:0] srcEnable,
    input wire logic [NSRC-1:0] prioHigh,
    input wire logic [NSRC-1:0] prioLow,
    // Core sequencer
    input wire flic_core_t core,
    // Grant to the core
    output flic_grant_t grant,
    output logic pushPc,
    output logic loadPc,
    output logic timerAClear,
    output logic timerBClear,
    output logic [NLVL-1:0] inService,
    output logic wakeRequest,
    output logic [3:0] extFlag
);
    logic [3:0] extFlagW;
    logic [3:0] vecClr_ff;
    flic_grant_t grant_ff;
    logic pushPc_ff;
    logic loadPc_ff;
    logic timerAClear_ff;
    logic timerBClear_ff;
    logic [NLVL-1:0] inSvc_ff;
    logic wake_ff;
    logic [3:0] extFlag_ff;

    flic_edge_latch u_ext (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .extPinN(extPinN),
        .extTriggerType(extTriggerType),
        .swSet(extSwSet),
        .swClr(extSwClr),
        .vecClr(vecClr_ff),
        .extFlag(extFlagW)
    );

    // One plus index of highest set bit in a level vector, zero if none set
    function automatic logic [2:0] topLevel(input logic [NLVL-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < NLVL; i++) begin
            if (v[i]) r = 3'(i + 1);
        end
        return r;
    endfunction

    // [RQ4] shared sources OR flags; [RQ17] any set flag counts
    wire [NSRC-1:0] rawReq = {brownoutFlag, wakeTimerFlag,
        spiDoneFlag | spiFaultFlag | spiOverrunFlag,
        extFlagW[3], extFlagW[2],
        timerCOverflowFlag | timerCExternalFlag,
        serialReceiveFlag | serialTransmitFlag,
        timerBOverflowFlag, extFlagW[1], timerAOverflowFlag, extFlagW[0]};
    // [RQ16] global and per-source gating
    wire [NSRC-1:0] enReq = rawReq & srcEnable & {NSRC{globalIrqEnable}};

    // [RQ8] poll and resolve within the cycle; [RQ3] lowest rank wins
    logic [3:0] winSrc;
    logic [1:0] winLvl;
    logic winValid;
    always_comb begin
        logic [1:0] l;
        l = 2'h0;
        winSrc = 4'h0;
        winLvl = 2'h0;
        winValid = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            // [RQ1] level from high and low bits
            l = {prioHigh[i], prioLow[i]};
            if (enReq[i] && (!winValid || l >= winLvl)) begin
                winSrc = 4'(i);
                winLvl = l;
                winValid = 1'b1;
            end
        end
    end

    // [RQ2] strictly higher than active level only
    wire [2:0] activeTop = topLevel(inSvc_ff);
    wire notBlocked = ({1'b0, winLvl} + 3'h1) > activeTop;
    // [RQ15] one-cycle detect keeps worst case bounded
    // [RQ9] three call conditions; [RQ10] no memory kept
    wire doCall = winValid && notBlocked && core.lastCycle && !core.writesCfg && !core.isReti
        && !pushPc_ff;
    // [RQ4] vector address by rank
    wire [15:0] vecAddr = VEC_BASE + 16'(winSrc) * VEC_STEP;
    // [RQ18] clear highest in service on RETI
    wire [NLVL-1:0] retiMask = (core.lastCycle && core.isReti && activeTop != 3'h0)
        ? NLVL'(1 << (activeTop - 3'h1)) : '0;
    wire [NLVL-1:0] setMask = doCall ? NLVL'(1 << winLvl) : '0;
    // [RQ5] wake only from allowed sources
    wire nxtWake = |(enReq & WAKE_MASK);
    // [RQ6] edge-mode external flags cleared on vector
    wire [3:0] nxtVecClr = doCall ? {winSrc == 4'(SRC_EXT3), winSrc == 4'(SRC_EXT2),
        winSrc == 4'(SRC_EXT1), winSrc == 4'(SRC_EXT0)} : 4'h0;

    // Grant and call sequencing
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            grant_ff <= '0;
            pushPc_ff <= 1'b0;
            loadPc_ff <= 1'b0;
        end else begin
            // [RQ11] push PC only, then load vector; [RQ14] two cycles
            pushPc_ff <= doCall;
            loadPc_ff <= pushPc_ff;
            if (doCall) begin
                grant_ff <= '{valid: 1'b1, src: winSrc, level: winLvl, vector: vecAddr};
            end else if (loadPc_ff) begin
                grant_ff.valid <= 1'b0;
            end
        end
    end

    // Service tracking and flag clears
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            inSvc_ff <= INSVC_RESET;
            vecClr_ff <= 4'h0;
            timerAClear_ff <= 1'b0;
            timerBClear_ff <= 1'b0;
            wake_ff <= 1'b0;
            extFlag_ff <= EXT_RESET;
        end else begin
            // [RQ12] only RETI ends service; set wins over clear
            inSvc_ff <= (inSvc_ff & ~retiMask) | setMask;
            vecClr_ff <= nxtVecClr;
            // [RQ7] timers zero and one cleared, third timer not
            timerAClear_ff <= doCall && winSrc == 4'(SRC_TMRA);
            timerBClear_ff <= doCall && winSrc == 4'(SRC_TMRB);
            wake_ff <= nxtWake;
            extFlag_ff <= extFlagW;
        end
    end

    assign grant = grant_ff;
    assign pushPc = pushPc_ff;
    assign loadPc = loadPc_ff;
    assign timerAClear = timerAClear_ff;
    assign timerBClear = timerBClear_ff;
    assign inService = inSvc_ff;
    assign wakeRequest = wake_ff;
    assign extFlag = extFlag_ff;
endmodule

//--- bench/flic_properties.sv
`timescale 1ns/1ps
// Port-level checks on the controller outputs
module flic_properties
    import flic_pkg::*;
(
    // Clock and reset
    input logic clk_sys,
    input logic rstn,
    // Sources and core
    input logic [3:0] extPinN,
    input logic [3:0] extTriggerType,
    input logic wakeTimerFlag,
    input logic brownoutFlag,
    input logic globalIrqEnable,
    input flic_core_t core,
    // Outputs watched
    input flic_grant_t grant,
    input logic pushPc,
    input logic loadPc,
    input logic timerAClear,
    input logic timerBClear,
    input logic [NLVL-1:0] inService,
    input logic wakeRequest,
    input logic [3:0] extFlag
);
    // One machine-cycle clock for every check
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    call_two_cycles_a: assert property (pushPc |=> loadPc && !pushPc)
        else $error("call not two cycles");
    call_gate_a: assert property (pushPc |-> $past(core.lastCycle && !core.writesCfg
        && !core.isReti && globalIrqEnable)) else $error("call at a bad boundary");
    vector_addr_a: assert property (pushPc |-> grant.valid
        && grant.vector == VEC_BASE + VEC_STEP * 16'(grant.src)) else $error("bad vector");
    level_block_a: assert property (pushPc |-> !$past(inService[3])
        && inService[grant.level]) else $error("bad in-service update");
    service_hold_a: assert property ($past(rstn) && !pushPc
        && !$past(core.lastCycle && core.isReti)
        |-> $stable(inService)) else $error("in-service moved without return");
    timer_clear_a: assert property (timerAClear || timerBClear |-> pushPc
        && grant.src == {2'b00, timerBClear, 1'b1}) else $error("stray timer clear");
    wake_source_a: assert property (wakeRequest |-> (|extFlag)
        || $past(wakeTimerFlag || brownoutFlag)) else $error("wake from wrong source");
    level_track_a: assert property ($past(rstn) && $past(rstn, 2) && $past(rstn, 3)
        && !extTriggerType[0] && $past(!extTriggerType[0], 2)
        |-> extFlag[0] == !$past(extPinN[0], 2)) else $error("level flag not tracking pin");
endmodule
bind flic_ctrl flic_properties flic_properties_i (.clk_sys, .rstn, .extPinN, .extTriggerType,
    .wakeTimerFlag, .brownoutFlag, .globalIrqEnable, .core, .grant, .pushPc, .loadPc,
    .timerAClear, .timerBClear, .inService, .wakeRequest, .extFlag);

//--- bench/flic_core_model.sv
`timescale 1ns/1ps
// Core sequencer: random instruction lengths, stalled by the call
module flic_core_model
    import flic_pkg::*;
(
    // Clock and reset
    input logic clk_sys,
    input logic rstn,
    // Controller side
    input logic pushPc,
    input logic wantReti,
    output flic_core_t core
);
    logic [1:0] left_ff;
    logic cfg_ff;
    logic reti_ff;
    assign core = '{lastCycle: left_ff == 2'h0, writesCfg: cfg_ff, isReti: reti_ff};
    // call stall, up to four cycles, return only in service
    always_ff @(posedge clk_sys) begin
        if (!rstn || pushPc) begin
            left_ff <= 2'h1;
            cfg_ff <= 1'b0;
            reti_ff <= 1'b0;
        end else if (left_ff != 2'h0) begin
            left_ff <= left_ff - 2'h1;
        end else begin
            left_ff <= 2'($urandom_range(3, 0));
            cfg_ff <= ($urandom_range(3, 0) == 0);
            reti_ff <= wantReti && $urandom_range(1, 0);
        end
    end
endmodule

//--- bench/flic_ctrl_tb_top.sv
`timescale 1ns/1ps
// Random sources against a reference arbiter
module flic_ctrl_tb_top
    import flic_pkg::*;
();
    logic clk_sys, rstn, ge, pushPc, loadPc, okQ, geQ, clrA, clrB, wk;
    logic [10:0] r;
    logic [15:0] f, fQ;
    logic [3:0] pins, typ, sset, sclr, inService, extFlag, svQ;
    logic [10:0] en, hi, lo, enQ, hiQ, loQ;
    logic [6:0] e;
    flic_core_t core;
    flic_grant_t grant;
    int failures, num_checks;
    flic_ctrl flic_ctrl_i (.clk_sys, .rstn, .extPinN(pins), .extTriggerType(typ),
        .extSwSet(sset), .extSwClr(sclr), .timerAOverflowFlag(f[1]),
        .timerBOverflowFlag(f[3]), .timerCOverflowFlag(f[5]), .timerCExternalFlag(f[12]),
        .serialReceiveFlag(f[4]), .serialTransmitFlag(f[11]), .spiDoneFlag(f[8]),
        .spiFaultFlag(f[13]), .spiOverrunFlag(f[14]), .wakeTimerFlag(f[9]),
        .brownoutFlag(f[10]), .globalIrqEnable(ge), .srcEnable(en), .prioHigh(hi),
        .prioLow(lo), .core, .grant, .pushPc, .loadPc, .timerAClear(clrA), .timerBClear(clrB),
        .inService, .wakeRequest(wk), .extFlag);
    flic_core_model flic_core_model_i (.clk_sys, .rstn, .pushPc, .wantReti(|inService), .core);
    function automatic logic [10:0] reqs(input logic [15:0] v, input logic [3:0] x);
        return (v[10:0] & 11'h73A) | {2'b00, v[14] | v[13], x[3], x[2], v[12], v[11], 1'b0,
            x[1], 1'b0, x[0]};
    endfunction
    function automatic logic [6:0] pick(input logic [10:0] r, h, l, input logic [3:0] s);
        logic [6:0] b;
        b = 7'h00;
        for (int i = 10; i >= 0; i--) begin
            if (r[i] && (!b[6] || {h[i], l[i]} >= b[5:4])) b = {1'b1, h[i], l[i], 4'(i)};
        end
        if ((s >> b[5:4]) != 4'h0) b[6] = 1'b0;
        return b;
    endfunction
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
        num_checks++;
        if (s !== x) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Run is about 12k cycles; the limit leaves headroom
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        wrap_up;
    end
    // Each boundary judged afresh; ext flags show one cycle late
    always @(posedge clk_sys) begin
        if (okQ) begin
            r = reqs(fQ, extFlag) & enQ & {11{geQ}};
            e = pick(r, hiQ, loQ, svQ);
            chk("call", 16'(pushPc), 16'(e[6]));
            chk("wake", 16'(wk), 16'(|(r & WAKE_MASK)));
            chk("tmrA clear", 16'(clrA), 16'(e[6] && e[3:0] == 4'(SRC_TMRA)));
            chk("tmrB clear", 16'(clrB), 16'(e[6] && e[3:0] == 4'(SRC_TMRB)));
            if (e[6]) begin
                chk("source", 16'(grant.src), 16'(e[3:0]));
                chk("vector", grant.vector, VEC_BASE + VEC_STEP * 16'(e[3:0]));
                chk("level", 16'(inService), 16'(svQ | (4'h1 << e[5:4])));
            end
        end
        okQ = rstn && core.lastCycle && !core.writesCfg && !core.isReti && !pushPc;
        {geQ, fQ, enQ, hiQ, loQ, svQ} = {ge, f, en, hi, lo, inService};
    end
    // Phases: global off, one shared level, random, mid-run reset
    initial begin
        {rstn, ge, f, pins, typ, sset, sclr, en, hi, lo, okQ} = '0;
        failures = 0;
        num_checks = 0;
        void'($urandom(34160));
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            @(posedge clk_sys);
            rstn <= (t != 3);
            ge <= (t != 0);
            en <= (t == 0) ? 11'h7FF : 11'($urandom);
            hi <= (t == 1) ? 11'h000 : 11'($urandom);
            lo <= (t == 1) ? 11'h000 : 11'($urandom);
            typ <= 4'($urandom);
            repeat (3000) begin
                @(posedge clk_sys);
                rstn <= 1'b1;
                f <= 16'($urandom) & 16'($urandom) & 16'($urandom);
                pins <= 4'($urandom);
                sset <= 4'($urandom) & 4'($urandom);
                sclr <= 4'($urandom) & 4'($urandom);
            end
            $display("test %0d done", t);
        end
        wrap_up;
    end
endmodule
